// ===== logic/ssb_pkg.sv
// Shared constants and types for the shift and bit-set unit.
// Assumes a decoder that presents whole instruction words and operands.
package ssb_pkg;

  // Operand sizes
  typedef enum logic [1:0] {
    SSB_SZ_BYTE = 2'h0,
    SSB_SZ_WORD = 2'h1,
    SSB_SZ_LONG = 2'h2
  } ssb_size_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    SSB_ST_IDLE = 2'h1,
    SSB_ST_RUN  = 2'h2
  } ssb_state_t;

  // First-word opcode fields
  localparam logic [7:0] SSB_OPC_SHIFT_WL = 8'hb3;
  localparam logic [7:0] SSB_OPC_SHIFT_B  = 8'hb2;
  localparam logic [3:0] SSB_SUB_DA_WB    = 4'hb;
  localparam logic [3:0] SSB_SUB_DA_L     = 4'hf;
  localparam logic [3:0] SSB_SUB_DL_WB    = 4'h3;
  localparam logic [3:0] SSB_SUB_DL_L     = 4'h7;
  localparam logic [3:0] SSB_SUB_SLA_WB   = 4'h9;
  localparam logic [3:0] SSB_SUB_SLA_L    = 4'hd;
  localparam logic [6:0] SSB_OPC_BIT_R    = 7'h52;
  localparam logic [6:0] SSB_OPC_BIT_IR   = 7'h12;
  localparam logic [6:0] SSB_OPC_BIT_DA   = 7'h32;
  localparam logic [7:0] SSB_OPC_FLAG     = 8'h8d;
  localparam logic [3:0] SSB_FLAG_LOW     = 4'h1;

  // Flag bit positions
  localparam int SSB_FLG_C  = 7;
  localparam int SSB_FLG_Z  = 6;
  localparam int SSB_FLG_S  = 5;
  localparam int SSB_FLG_PV = 4;

  // Left-alignment distances per size
  localparam logic [5:0] SSB_ALIGN_BYTE = 6'h18;
  localparam logic [5:0] SSB_ALIGN_WORD = 6'h10;
  localparam logic [5:0] SSB_ALIGN_LONG = 6'h00;

  // Cycle counts
  localparam logic [7:0] SSB_CYC_SH_DYN  = 8'h0f;
  localparam logic [7:0] SSB_CYC_SH_IMM  = 8'h0d;
  localparam logic [7:0] SSB_CYC_PER_BIT = 8'h03;
  localparam logic [7:0] SSB_CYC_BIT_R   = 8'h04;
  localparam logic [7:0] SSB_CYC_BIT_IR  = 8'h0b;
  localparam logic [7:0] SSB_CYC_BIT_DYN = 8'h0a;
  localparam logic [7:0] SSB_CYC_DA_NS   = 8'h0d;
  localparam logic [7:0] SSB_CYC_DA_SS   = 8'h0e;
  localparam logic [7:0] SSB_CYC_DA_SL   = 8'h10;
  localparam logic [7:0] SSB_CYC_X_NS    = 8'h0e;
  localparam logic [7:0] SSB_CYC_X_SS    = 8'h0e;
  localparam logic [7:0] SSB_CYC_X_SL    = 8'h11;
  localparam logic [7:0] SSB_CYC_FLAG    = 8'h07;
  localparam logic [7:0] SSB_CYC_BAD     = 8'h01;

endpackage

// ===== logic/ssb_dp_if.sv
// Datapath carrier between the sequencer and its two arithmetic leaves.
// Assumes all signals are combinational within one clock cycle.
interface ssb_dp_if;
  import ssb_pkg::*;

  logic [31:0] sh_operand;
  ssb_size_t   sh_size;
  logic [15:0] sh_count;
  logic        sh_arith;
  logic [31:0] sh_result;
  logic        sh_carry;
  logic        sh_ovf;
  logic [5:0]  sh_steps;
  logic [15:0] bs_operand;
  logic [3:0]  bs_bitnum;
  logic        bs_byte;
  logic [15:0] bs_result;

  modport ctl  (output sh_operand, sh_size, sh_count, sh_arith,
                output bs_operand, bs_bitnum, bs_byte,
                input  sh_result, sh_carry, sh_ovf, sh_steps, bs_result);
  modport shf  (input  sh_operand, sh_size, sh_count, sh_arith,
                output sh_result, sh_carry, sh_ovf, sh_steps);
  modport bset (input  bs_operand, bs_bitnum, bs_byte,
                output bs_result);
endinterface

// ===== logic/ssb_shifter.sv
// Combinational signed-count shifter for byte, word and long operands.
// Assumes the caller picks arithmetic or logical fill and the size.
module ssb_shifter
  import ssb_pkg::*;
(
  ssb_dp_if.shf dp
);

  logic        neg;
  logic [15:0] mag;
  logic [5:0]  amt;
  logic [5:0]  align;
  logic [31:0] a;
  logic [63:0] lt;
  logic [63:0] rt;
  logic [63:0] rs;
  logic [31:0] diff;
  logic [31:0] top_mask;
  logic [31:0] aligned;

  // Work on a left-aligned copy so one path serves every size
  always_comb begin
    // RULE5 signed count direction
    neg = dp.sh_count[15];
    mag = neg ? (16'h0000 - dp.sh_count) : dp.sh_count;
    // RULE6 only six bits kept; larger counts undefined
    amt = mag[5:0];
    case (dp.sh_size)
      SSB_SZ_BYTE: align = SSB_ALIGN_BYTE;
      SSB_SZ_WORD: align = SSB_ALIGN_WORD;
      default:     align = SSB_ALIGN_LONG;
    endcase
    a = dp.sh_operand << align;
    // RULE18 left fills zero
    lt = {32'h0000_0000, a} << amt;
    // RULE7 logical right zero fill, arithmetic sign fill
    if (dp.sh_arith) begin
      rt = $signed({a, 32'h0000_0000}) >>> amt;
    end else begin
      rt = {a, 32'h0000_0000} >> amt;
    end
    // Adjacent-bit changes among the bits that pass the sign
    diff     = a ^ {a[30:0], 1'b0};
    top_mask = ~(32'hffff_ffff >> amt);
    // Undo the alignment so the last bit out sits just below bit 32
    rs = rt >> align;
    // RULE8 zero count keeps the operand
    aligned = neg ? rt[63:32] : lt[31:0];
    dp.sh_result = aligned >> align;
    // RULE1 RULE19 carry from last bit out
    dp.sh_carry = (amt == 6'h00) ? 1'b0 : (neg ? rs[31] : lt[32]);
    // RULE1 overflow on sign change
    dp.sh_ovf   = dp.sh_arith & ~neg & (|(diff & top_mask));
    dp.sh_steps = amt;
  end

endmodule

// ===== logic/ssb_bitset.sv
// Sets one selected bit of a byte or word operand.
// Assumes the bit number is already taken from register or opcode.
module ssb_bitset
  import ssb_pkg::*;
(
  ssb_dp_if.bset dp
);

  logic [3:0] sel;

  // RULE11 RULE12 low three or four bits
  assign sel = dp.bs_byte ? {1'b0, dp.bs_bitnum[2:0]} : dp.bs_bitnum;

  // RULE10 force only the chosen bit
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      assign dp.bs_result[i] = dp.bs_operand[i] | (sel == 4'(i));
    end
  endgenerate

endmodule

// ===== logic/ssb_unit.sv
// Shift and bit-set execution unit: decode, result, flags and timing.
// Assumes operands arrive with start and stay valid in that cycle only.
// Operation
// RULE1 - arithmetic shift fills, carry, sign-change overflow
// RULE2 - decode dynamic arithmetic shift words
// RULE3 - dynamic shifts take fifteen plus three per bit
// RULE4 - decode dynamic logical shift sub-codes
// RULE5 - count is signed sixteen bit, sign gives direction
// RULE6 - logical counts beyond size range undefined
// RULE7 - logical fills zero, carry from edge bit
// RULE8 - zero count keeps value, flags still computed
// RULE9 - zero and sign from result, D H kept
// RULE10 - bit-set forces one bit only
// RULE11 - register bit number uses low three/four bits
// RULE12 - immediate bit number from low field bits
// RULE13 - register bit-set four, indirect eleven cycles
// RULE14 - direct bit-set thirteen, fourteen or sixteen cycles
// RULE15 - dynamic bit-set two words, ten cycles
// RULE16 - flag-set ORs opcode bits seven to four
// RULE17 - parity and overflow share one flag
// RULE18 - immediate left shift fills zero, counts bounded
// RULE19 - immediate left carry from sign bit
// RULE20 - decode immediate left shift sub-codes
// RULE21 - immediate left takes thirteen plus three per bit
// RULE22 - long operand high half in even register
// RULE23 - undefined outcomes still finish on time
module ssb_unit
  import ssb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [15:0] instr_word0,
  input  wire logic [15:0] instr_word1,
  input  wire logic [15:0] dst_hi,
  input  wire logic [15:0] dst_lo,
  input  wire logic [15:0] src_val,
  input  wire logic [7:0]  flags_in,
  input  wire logic        seg_mode,
  output logic             busy,
  output logic             done,
  output logic [15:0]      result_hi,
  output logic [15:0]      result_lo,
  output logic             result_wr,
  output logic [7:0]       flags_out,
  output logic             flags_wr,
  output logic             illegal
);

  ssb_dp_if dp ();

  ssb_state_t  state_reg;
  logic [7:0]  cnt_reg;
  logic [31:0] pend_res_reg;
  logic [7:0]  pend_flags_reg;
  logic        pend_wr_reg;
  logic        pend_fwr_reg;
  logic        pend_bad_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [31:0] result_reg;
  logic        result_wr_reg;
  logic [7:0]  flags_reg;
  logic        flags_wr_reg;
  logic        illegal_reg;

  logic [7:0]  op_hi;
  logic [3:0]  sub;
  logic [3:0]  fld;
  logic        byte_op;
  logic        long_op;
  logic        dyn_sh;
  logic        imm_sh;
  logic        w1_clean;
  logic [5:0]  steps;
  logic [7:0]  sh_cycles;
  logic        sh_zero;
  logic        sh_sign;
  logic [7:0]  dec_cyc;
  logic [31:0] dec_res;
  logic [7:0]  dec_flags;
  logic        dec_wr;
  logic        dec_fwr;
  logic        dec_bad;
  logic        finish;

  ssb_shifter u_shifter (
    .dp (dp.shf)
  );

  ssb_bitset u_bitset (
    .dp (dp.bset)
  );

  // Instruction field split
  assign op_hi    = instr_word0[15:8];
  assign sub      = instr_word0[3:0];
  assign fld      = instr_word0[7:4];
  // RULE2 RULE15 second word has only a register field
  assign w1_clean = (instr_word1[15:12] == 4'h0) && (instr_word1[7:0] == 8'h00);
  assign finish   = (state_reg == SSB_ST_RUN) && (cnt_reg == 8'h01);

  // Shift family classification
  always_comb begin
    byte_op = (op_hi == SSB_OPC_SHIFT_B);
    long_op = 1'b0;
    dyn_sh  = 1'b0;
    imm_sh  = 1'b0;
    dp.sh_arith = 1'b1;
    if ((op_hi == SSB_OPC_SHIFT_WL) || byte_op) begin
      // RULE2 dynamic arithmetic sub-codes
      if (sub == SSB_SUB_DA_WB) begin
        dyn_sh = 1'b1;
      end else if ((sub == SSB_SUB_DA_L) && !byte_op) begin
        dyn_sh  = 1'b1;
        long_op = 1'b1;
      // RULE4 dynamic logical sub-codes
      end else if (sub == SSB_SUB_DL_WB) begin
        dyn_sh      = 1'b1;
        dp.sh_arith = 1'b0;
      end else if ((sub == SSB_SUB_DL_L) && !byte_op) begin
        dyn_sh      = 1'b1;
        long_op     = 1'b1;
        dp.sh_arith = 1'b0;
      // RULE20 immediate left sub-codes
      end else if (sub == SSB_SUB_SLA_WB) begin
        imm_sh = 1'b1;
      end else if ((sub == SSB_SUB_SLA_L) && !byte_op) begin
        imm_sh  = 1'b1;
        long_op = 1'b1;
      end
    end
  end

  // Shifter operand, size and count
  always_comb begin
    // RULE22 even register is the high half
    if (long_op) begin
      dp.sh_operand = {dst_hi, dst_lo};
      dp.sh_size    = SSB_SZ_LONG;
    end else begin
      dp.sh_operand = {16'h0000, dst_lo};
      dp.sh_size    = byte_op ? SSB_SZ_BYTE : SSB_SZ_WORD;
    end
    // RULE20 positive count in the following word
    if (dyn_sh) begin
      dp.sh_count = src_val;
    end else if (byte_op) begin
      dp.sh_count = {{8{instr_word1[7]}}, instr_word1[7:0]};
    end else begin
      dp.sh_count = instr_word1;
    end
  end

  // RULE3 RULE21 zero steps cost as one step
  assign steps     = (dp.sh_steps == 6'h00) ? 6'h01 : dp.sh_steps;
  assign sh_cycles = (dyn_sh ? SSB_CYC_SH_DYN : SSB_CYC_SH_IMM)
                     + SSB_CYC_PER_BIT * {2'b00, steps};

  // RULE9 zero and sign from the sized result
  assign sh_zero = (dp.sh_result == 32'h0000_0000);
  always_comb begin
    case (dp.sh_size)
      SSB_SZ_BYTE: sh_sign = dp.sh_result[7];
      SSB_SZ_WORD: sh_sign = dp.sh_result[15];
      default:     sh_sign = dp.sh_result[31];
    endcase
  end

  // Bit-set operand and bit number source
  always_comb begin
    dp.bs_operand = dst_lo;
    dp.bs_byte    = ~instr_word0[8];
    // RULE11 dynamic form takes the register value
    if ((instr_word0[15:9] == SSB_OPC_BIT_IR) && (fld == 4'h0)) begin
      dp.bs_bitnum = src_val[3:0];
    end else begin
      // RULE12 immediate bit number from field
      dp.bs_bitnum = sub;
    end
  end

  // Full decode: result, flags, timing and legality
  always_comb begin
    dec_cyc   = SSB_CYC_BAD;
    dec_res   = {dst_hi, dst_lo};
    dec_flags = flags_in;
    dec_wr    = 1'b0;
    dec_fwr   = 1'b0;
    dec_bad   = 1'b1;
    if ((dyn_sh && w1_clean) || imm_sh) begin
      // RULE23 any count still completes on time
      dec_cyc = sh_cycles;
      dec_wr  = 1'b1;
      dec_fwr = 1'b0 | 1'b1;
      dec_bad = 1'b0;
      case (dp.sh_size)
        SSB_SZ_BYTE: dec_res = {dst_hi, dst_lo[15:8], dp.sh_result[7:0]};
        SSB_SZ_WORD: dec_res = {dst_hi, dp.sh_result[15:0]};
        default:     dec_res = dp.sh_result;
      endcase
      // RULE9 D and H pass through
      dec_flags = {dp.sh_carry, sh_zero, sh_sign, dp.sh_ovf, flags_in[3:0]};
    end else if (instr_word0[15:9] == SSB_OPC_BIT_R) begin
      // RULE13 register form four cycles
      dec_cyc = SSB_CYC_BIT_R;
      dec_res = {dst_hi, dp.bs_result};
      dec_wr  = 1'b1;
      dec_bad = 1'b0;
    end else if (instr_word0[15:9] == SSB_OPC_BIT_IR) begin
      if (fld != 4'h0) begin
        // RULE13 indirect form eleven cycles
        dec_cyc = SSB_CYC_BIT_IR;
        dec_res = {dst_hi, dp.bs_result};
        dec_wr  = 1'b1;
        dec_bad = 1'b0;
      end else if ((sub == 4'h0) && w1_clean) begin
        // RULE15 dynamic form ten cycles
        dec_cyc = SSB_CYC_BIT_DYN;
        dec_res = {dst_hi, dp.bs_result};
        dec_wr  = 1'b1;
        dec_bad = 1'b0;
      end
    end else if (instr_word0[15:9] == SSB_OPC_BIT_DA) begin
      dec_res = {dst_hi, dp.bs_result};
      dec_wr  = 1'b1;
      dec_bad = 1'b0;
      // RULE14 direct form by mode and offset length
      if (fld == 4'h0) begin
        if (!seg_mode) begin
          dec_cyc = SSB_CYC_DA_NS;
        end else if (instr_word1[15]) begin
          dec_cyc = SSB_CYC_DA_SL;
        end else begin
          dec_cyc = SSB_CYC_DA_SS;
        end
      end else begin
        // Indexed form shares the opcode with a base register
        if (!seg_mode) begin
          dec_cyc = SSB_CYC_X_NS;
        end else if (instr_word1[15]) begin
          dec_cyc = SSB_CYC_X_SL;
        end else begin
          dec_cyc = SSB_CYC_X_SS;
        end
      end
    end else if ((op_hi == SSB_OPC_FLAG) && (sub == SSB_FLAG_LOW)) begin
      // RULE16 RULE17 OR into C Z S and shared P/V
      dec_cyc   = SSB_CYC_FLAG;
      dec_flags = flags_in | {fld, 4'h0};
      dec_fwr   = 1'b1;
      dec_bad   = 1'b0;
    end
  end

  // Sequencer: load cycle count on start, count down to finish
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= SSB_ST_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      case (state_reg)
        SSB_ST_IDLE: begin
          if (start) begin
            state_reg <= SSB_ST_RUN;
            cnt_reg   <= dec_cyc;
          end
        end
        SSB_ST_RUN: begin
          // RULE3 RULE13 RULE21 fixed latency, never stalls
          if (cnt_reg == 8'h01) begin
            state_reg <= SSB_ST_IDLE;
          end
          cnt_reg <= cnt_reg - 8'h01;
        end
        default: begin
          state_reg <= SSB_ST_IDLE;
          cnt_reg   <= 8'h00;
        end
      endcase
    end
  end

  // Capture decoded outcome; operands need only be valid at start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_res_reg   <= 32'h0000_0000;
      pend_flags_reg <= 8'h00;
      pend_wr_reg    <= 1'b0;
      pend_fwr_reg   <= 1'b0;
      pend_bad_reg   <= 1'b0;
    end else if ((state_reg == SSB_ST_IDLE) && start) begin
      pend_res_reg   <= dec_res;
      pend_flags_reg <= dec_flags;
      pend_wr_reg    <= dec_wr;
      pend_fwr_reg   <= dec_fwr;
      pend_bad_reg   <= dec_bad;
    end
  end

  // Busy level from start until completion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else if ((state_reg == SSB_ST_IDLE) && start) begin
      busy_reg <= 1'b1;
    end else if (finish) begin
      busy_reg <= 1'b0;
    end
  end

  // Completion pulse and write strobes, one cycle each
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_reg      <= 1'b0;
      result_wr_reg <= 1'b0;
      flags_wr_reg  <= 1'b0;
      illegal_reg   <= 1'b0;
    end else begin
      done_reg      <= finish;
      result_wr_reg <= finish & pend_wr_reg;
      flags_wr_reg  <= finish & pend_fwr_reg;
      illegal_reg   <= finish & pend_bad_reg;
    end
  end

  // Result and flags held until the next completion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_reg <= 32'h0000_0000;
      flags_reg  <= 8'h00;
    end else if (finish) begin
      result_reg <= pend_res_reg;
      flags_reg  <= pend_flags_reg;
    end
  end

  // Outputs straight from flip-flops
  assign busy      = busy_reg;
  assign done      = done_reg;
  assign result_hi = result_reg[31:16];
  assign result_lo = result_reg[15:0];
  assign result_wr = result_wr_reg;
  assign flags_out = flags_reg;
  assign flags_wr  = flags_wr_reg;
  assign illegal   = illegal_reg;

endmodule

// ===== testbench/ssb_unit_props.sv
// Port checker for the shift and bit-set unit.
// Assumes a bind onto ssb_unit; sees only its ports.
module ssb_unit_props
  import ssb_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [15:0] instr_word0,
  input wire logic [15:0] instr_word1,
  input wire logic [15:0] dst_hi,
  input wire logic [15:0] dst_lo,
  input wire logic [15:0] src_val,
  input wire logic [7:0]  flags_in,
  input wire logic        seg_mode,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [15:0] result_hi,
  input wire logic [15:0] result_lo,
  input wire logic        result_wr,
  input wire logic [7:0]  flags_out,
  input wire logic        flags_wr,
  input wire logic        illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Request taken while idle, then split by kind
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_flag;
    s_take ##0 (instr_word0[15:8] == SSB_OPC_FLAG && instr_word0[3:0] == SSB_FLAG_LOW);
  endsequence
  sequence s_bit_reg;
    s_take ##0 (instr_word0[15:9] == SSB_OPC_BIT_R);
  endsequence
  sequence s_bit_dyn;
    s_take ##0 (instr_word0[15:9] == SSB_OPC_BIT_IR && instr_word0[7:0] == 8'h00
      && instr_word1[15:12] == 4'h0 && instr_word1[7:0] == 8'h00);
  endsequence

  // Flags captured at the take edge, so later input garbage cannot mask a slip
  property p_flag;
    logic [7:0] f;
    (s_flag, f = flags_in | {instr_word0[7:4], 4'h0})
      |-> ##8 (done && flags_wr && flags_out == f);
  endproperty

  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without a busy period");
  a_strobes_need_done: assert property ((result_wr || flags_wr || illegal) |-> done)
    else $error("write strobe without done");
  a_take_sets_busy: assert property (s_take |=> busy)
    else $error("taken request left unit idle");
  a_flag_or_result: assert property (p_flag)
    else $error("flag-set value or timing wrong");
  a_bit_reg_time: assert property (s_bit_reg |-> ##5 (done && result_wr && !flags_wr))
    else $error("register bit-set timing wrong");
  a_bit_dyn_time: assert property (s_bit_dyn |-> ##11 (done && result_wr))
    else $error("dynamic bit-set timing wrong");
  a_result_held: assert property ($changed({result_hi, result_lo}) |-> done)
    else $error("result moved without done");
  a_flags_held: assert property ($changed(flags_out) |-> done)
    else $error("flags moved without done");
endmodule

// ===== testbench/ssb_dec_model.sv
// Decoder stand-in that issues one instruction at a time.
// Assumes its task is called just after a rising clock edge.
module ssb_dec_model
  import ssb_pkg::*;
(
  input  wire logic   clk,
  output logic        start,
  output logic [15:0] instr_word0,
  output logic [15:0] instr_word1,
  output logic [15:0] dst_hi,
  output logic [15:0] dst_lo,
  output logic [15:0] src_val,
  output logic [7:0]  flags_in,
  output logic        seg_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle values at time zero
  initial begin
    start = 1'b0;
    {instr_word0, instr_word1, dst_hi, dst_lo, src_val, flags_in, seg_mode} = '0;
  end

  // One-cycle request; operands are inverted after the take edge
  // so a unit that samples late sees wrong data
  task automatic issue(input logic [15:0] w0, w1, hi, lo, s, input logic [7:0] f,
      input logic sg);
    start = 1'b1;
    {instr_word0, instr_word1, dst_hi, dst_lo, src_val, flags_in, seg_mode} =
      {w0, w1, hi, lo, s, f, sg};
    @(posedge clk);
    #1;
    start = 1'b0;
    {instr_word0, instr_word1, dst_hi, dst_lo, src_val, flags_in, seg_mode} =
      ~{w0, w1, hi, lo, s, f, sg};
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the shift and bit-set unit.
// Assumes the decoder stand-in and the port checker compile first.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
  import ssb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] hi, lo;
    logic [7:0]  fl;
    int          n;
    logic        rw, fw, il;
  } ssb_note_t;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        start, busy, done, seg_mode, result_wr, flags_wr, illegal;
  logic [15:0] instr_word0, instr_word1, dst_hi, dst_lo, src_val, result_hi, result_lo;
  logic [7:0]  flags_in, flags_out;
  logic [31:0] rng = 32'h0000003b;
  ssb_note_t   notes[$];
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t0 = 0;

  always #5 clk = ~clk;

  ssb_dec_model ssb_dec_model_i (.clk, .start, .instr_word0, .instr_word1, .dst_hi, .dst_lo,
    .src_val, .flags_in, .seg_mode);
  ssb_unit ssb_unit_i (.clk, .reset, .start, .instr_word0, .instr_word1, .dst_hi, .dst_lo,
    .src_val, .flags_in, .seg_mode, .busy, .done, .result_hi, .result_lo, .result_wr,
    .flags_out, .flags_wr, .illegal);

  // Watcher: oldest note against each completion, timed from the take edge
  always @(posedge clk) begin
    ssb_note_t e;
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("MISMATCH t=%0t got %h exp %h", $time, 1, 0);
      end else begin
        e = notes.pop_front();
        `CHK(cyc - t0, e.n + 1)
        `CHK({illegal, result_wr, flags_wr}, {e.il, e.rw, e.fw})
        if (e.rw) `CHK({result_hi, result_lo}, {e.hi, e.lo})
        if (e.fw) `CHK(flags_out, e.fl)
      end
    end
    if (start === 1'b1 && busy === 1'b0) t0 = cyc;
    cyc++;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Expected shift as {carry, overflow, value}; overflow only on arithmetic left
  function automatic logic [33:0] ref_sh(input logic [1:0] sz, input logic ar, input int cnt,
      input logic [31:0] v);
    int w;
    logic [31:0] r, m;
    logic c, o;
    w = 8 << sz;
    m = (w == 32) ? 32'hffffffff : (32'h00000001 << w) - 32'h00000001;
    r = v & m;
    c = 1'b0;
    o = 1'b0;
    for (int i = 0; i < ((cnt < 0) ? -cnt : cnt); i++) begin
      if (cnt > 0) begin
        c = r[w-1];
        r = (r << 1) & m;
        o |= r[w-1] != v[w-1];
      end else begin
        c = r[0];
        r = (r >> 1) | ({31'h0, ar & r[w-1]} << (w - 1));
      end
    end
    return {c, ar & o, r};
  endfunction

  task automatic final_report();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded wait for completion; a hang ends the run
  task automatic wait_done();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) return;
    end
    failures++;
    final_report();
  endtask

  task automatic run(input logic [15:0] w0, w1, hi, lo, s, input logic [7:0] f,
      input logic sg, input ssb_note_t nt);
    notes.push_back(nt);
    ssb_dec_model_i.issue(w0, w1, hi, lo, s, f, sg);
    wait_done();
  endtask

  task automatic shift(input logic [3:0] sub, input logic [1:0] sz, input int cnt);
    logic [31:0] v, res;
    logic [33:0] q;
    logic [7:0] fi, fe;
    v = xs();
    fi = v[7:0];
    v = xs();
    q = ref_sh(sz, sub[3], cnt, v);
    res = (sz == 2'h2) ? q[31:0] : (sz == 2'h1) ? {v[31:16], q[15:0]} : {v[31:8], q[7:0]};
    fe = {q[33], q[31:0] == 32'h0, q[(8 << sz) - 1], q[32], fi[3:0]};
    run({(sz == 2'h0) ? SSB_OPC_SHIFT_B : SSB_OPC_SHIFT_WL, 4'h4, sub},
      sub[1] ? 16'h0100 : cnt[15:0], v[31:16], v[15:0], cnt[15:0], fi, 1'b0,
      '{res[31:16], res[15:0], fe,
        (sub[1] ? 15 : 13) + 3 * ((cnt == 0) ? 1 : (cnt < 0) ? -cnt : cnt), 1'b1, 1'b1, 1'b0});
  endtask

  logic [3:0]  subs[9] = '{4'hb, 4'hb, 4'hf, 4'h3, 4'h3, 4'h7, 4'h9, 4'h9, 4'hd};
  int          nda[3] = '{13, 14, 16};
  int          nx[3] = '{14, 14, 17};
  logic [31:0] bad[3] = '{32'hffff0000, 32'hb24f0100, 32'hb34b0101};

  initial begin
    logic [31:0] v, u;
    logic [15:0] w0, w1, e;
    logic [3:0] b;
    int form, m, x, n;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int k = 0; k < 9; k++) begin
      shift(subs[k], k % 3, 0);
      shift(subs[k], k % 3, 8 << (k % 3));
      v = xs();
      shift(subs[k], k % 3, v % (8 << (k % 3)) + 1);
      if (subs[k][1]) begin
        shift(subs[k], k % 3, -(8 << (k % 3)));
        shift(subs[k], k % 3, -1 - (v % 7));
      end
    end
    $display("test shifts done");
    // every bit-set form, segment and offset kind
    for (int k = 0; k < 24; k++) begin
      v = xs();
      u = xs();
      form = k % 4;
      m = (k / 4) % 3;
      x = k / 12;
      w1 = 16'h0000;
      b = v[3:0];
      case (form)
        0: begin w0 = {SSB_OPC_BIT_R, v[8], 4'h3, v[3:0]}; n = 4; end
        1: begin w0 = {SSB_OPC_BIT_IR, v[8], 4'h5, v[3:0]}; n = 11; end
        2: begin w0 = {SSB_OPC_BIT_IR, v[8], 8'h00}; w1 = 16'h0300; b = v[19:16]; n = 10; end
        default: begin
          w0 = {SSB_OPC_BIT_DA, v[8], (x == 1) ? 4'h6 : 4'h0, v[3:0]};
          w1 = {m == 2, 15'h0abc};
          n = (x == 1) ? nx[m] : nda[m];
        end
      endcase
      e = v[8] ? u[15:0] | (16'h0001 << b) : {u[15:8], u[7:0] | (8'h01 << b[2:0])};
      run(w0, w1, 16'h5a5a, u[15:0], v[31:16], 8'h00, m != 0,
        '{16'h5a5a, e, 8'h00, n, 1'b1, 1'b0, 1'b0});
    end
    $display("test bit-set done");
    for (int k = 0; k < 16; k++) begin
      v = xs();
      run({SSB_OPC_FLAG, k[3:0], SSB_FLAG_LOW}, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        v[7:0], 1'b0, '{16'h0000, 16'h0000, v[7:0] | {k[3:0], 4'h0}, 7, 1'b0, 1'b1, 1'b0});
    end
    $display("test flag-set done");
    // undecoded words finish in one cycle
    for (int k = 0; k < 3; k++)
      run(bad[k][31:16], bad[k][15:0], 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b0,
        '{16'h0000, 16'h0000, 8'h00, 1, 1'b0, 1'b0, 1'b1});
    $display("test illegal done");
    // A request while busy must leave no trace
    v = xs();
    notes.push_back('{16'h0000, v[15:0] | 16'h0001, 8'h00, 4, 1'b1, 1'b0, 1'b0});
    ssb_dec_model_i.issue({SSB_OPC_BIT_R, 5'h12, 4'h0}, 16'h0000, 16'h0000, v[15:0],
      16'h0000, 8'h00, 1'b0);
    @(posedge clk);
    #1;
    ssb_dec_model_i.issue({SSB_OPC_FLAG, 4'hf, SSB_FLAG_LOW}, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 8'h00, 1'b0);
    wait_done();
    $display("test refused start done");
    // Reset in mid-shift clears strobes; the unit then runs normally
    ssb_dec_model_i.issue({SSB_OPC_SHIFT_WL, 4'h2, SSB_SUB_DA_L}, 16'h0100, 16'h1234,
      16'h5678, 16'h0020, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b1;
    @(posedge clk);
    #1;
    `CHK({busy, done, result_wr, flags_wr, illegal}, 5'h00)
    reset = 1'b0;
    run({SSB_OPC_FLAG, 4'h8, SSB_FLAG_LOW}, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'h01,
      1'b0, '{16'h0000, 16'h0000, 8'h81, 7, 1'b0, 1'b1, 1'b0});
    // Let the watcher take the last completion before the verdict
    @(posedge clk);
    #1;
    `CHK(notes.size(), 0)
    $display("test reset done");
    final_report();
  end
endmodule

bind ssb_unit ssb_unit_props ssb_unit_props_i (.clk, .reset, .start, .instr_word0,
  .instr_word1, .dst_hi, .dst_lo, .src_val, .flags_in, .seg_mode, .busy, .done, .result_hi,
  .result_lo, .result_wr, .flags_out, .flags_wr, .illegal);
